// [rtl/twcsm_pkg.sv]
package twcsm_pkg;

    // ------------------------------------------------------------
    // Serial mode field encodings
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SYNC = 3'h1;
    localparam logic [2:0] MODE_TWI = 3'h2;

    // ------------------------------------------------------------
    // Bit counts
    // ------------------------------------------------------------
    localparam logic [3:0] TWI_BITS = 4'h9;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] OVR_BIT = 4'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [7:0] TXBUF_RST = 8'h00;
    localparam logic [8:0] RXBUF_RST = 9'h000;
    localparam logic IDLE_LVL_RST = 1'b1;

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RUN = 2'b01,
        PH_EXTRA = 2'b10
    } twcsm_phase_t;

    typedef struct packed {
        twcsm_phase_t phase;
        logic iclk;
        logic [7:0] div_cnt;
        logic tclk_prev;
        logic scl_prev;
        logic sda_prev;
        logic [3:0] bit_cnt;
        logic [8:0] tx_sh;
        logic [7:0] rx_sh;
        logic [7:0] tx_buf;
        logic empty;
        logic [8:0] rx_buf;
        logic rx_full;
        logic ovr_now;
        logic overrun;
        logic wait_hold;
        logic low_hold;
        logic hold9;
        logic idle_lvl;
        logic sda_bit;
        logic [7:0] dly;
        logic scl_oe;
        logic sda_oe;
        logic sda_out;
        logic clk_out;
        logic clk_oe;
        logic tx_irq;
        logic rx_irq;
        logic ack_irq;
        logic nack_irq;
        logic start_irq;
        logic stop_irq;
    } twcsm_state_t;

    localparam twcsm_state_t STATE_RST = '{
        phase: PH_IDLE,
        iclk: 1'b1,
        div_cnt: DIV_RST,
        tclk_prev: 1'b1,
        scl_prev: 1'b1,
        sda_prev: 1'b1,
        bit_cnt: 4'h0,
        tx_sh: 9'h000,
        rx_sh: 8'h00,
        tx_buf: TXBUF_RST,
        empty: 1'b1,
        rx_buf: RXBUF_RST,
        rx_full: 1'b0,
        ovr_now: 1'b0,
        overrun: 1'b0,
        wait_hold: 1'b0,
        low_hold: 1'b0,
        hold9: 1'b0,
        idle_lvl: IDLE_LVL_RST,
        sda_bit: 1'b1,
        dly: 8'hff,
        scl_oe: 1'b0,
        sda_oe: 1'b0,
        sda_out: 1'b0,
        clk_out: 1'b1,
        clk_oe: 1'b0,
        tx_irq: 1'b0,
        rx_irq: 1'b0,
        ack_irq: 1'b0,
        nack_irq: 1'b0,
        start_irq: 1'b0,
        stop_irq: 1'b0
    };

endpackage

// [rtl/twcsm_sync.sv]
`timescale 1ns/1ps
module twcsm_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Pin levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } twcsm_sync_state_t;

    twcsm_sync_state_t s_q;
    twcsm_sync_state_t s_d;

    // Idle bus lines are high, so reset to ones
    always_comb begin
        s_d = s_q;
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

// [rtl/twcsm_core.sv]
// Functional notes
// - Two-wire transfer clock with internal source is internal clock AND line
// - Wait hold keeps clock low after ninth fall
// - Stop releases clock line when enabled
// - Force-low drives clock line low anytime in two-wire mode
// - Phase hold lows clock after tenth fall
// - Data leaves MSB first, ninth is ack
// - Idle data level writable only when disabled
// - Output disable floats data line always
// - Ack mode 0 stores eight bits, ninth ack
// - Ack mode 1 layout, phase rewrites later
// - Ack value driven when enabled and condition output not selected
// - Ninth rising edge signals ack or nack in ack mode 0
// - Start reloads transmitter, holds data, keeps flag
// - Start resets receiver and sets wait hold
// - Synchronous mode: 8 bits, divide 2(n+1)
// - Transfer starts with enable, data, idle clock
// - Transmit and receive event timing
// - Seventh bit with full buffer flags overrun
// - Four clock phase and polarity choices
// - Start and stop condition detection
// - Clock synchronisation with the line clock
`timescale 1ns/1ps
module twcsm_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Mode selection
    input wire logic two_wire_mode_select,
    input wire logic [2:0] serial_mode_field,
    input wire logic clock_source_select,
    input wire logic [7:0] baud_divider,
    input wire logic clock_phase_bit,
    input wire logic clock_polarity_bit,
    input wire logic clock_sync_enable,
    // Clock line control
    input wire logic clock_force_low,
    input wire logic hold_after_ninth,
    input wire logic clock_release_on_stop,
    input wire logic clock_wait_hold_wr,
    input wire logic clock_wait_hold_wdata,
    // Data line control
    input wire logic [2:0] data_delay_field,
    input wire logic data_output_disable,
    input wire logic idle_level_wr,
    input wire logic idle_level_wdata,
    input wire logic ack_drive_enable,
    input wire logic ack_value_bit,
    input wire logic condition_output_select,
    // Transfer control
    input wire logic ack_interrupt_mode,
    input wire logic init_on_start_enable,
    input wire logic transmit_enable_bit,
    input wire logic receive_enable_bit,
    input wire logic transmit_irq_cause_select,
    // Buffers
    input wire logic tx_write,
    input wire logic [7:0] tx_wdata,
    input wire logic rx_read,
    input wire logic overrun_clear,
    // Status
    output logic buffer_empty_flag,
    output logic [8:0] receive_buffer,
    output logic receive_full,
    output logic overrun_flag,
    output logic clock_wait_hold,
    // Events
    output logic tx_irq,
    output logic rx_irq,
    output logic ack_irq,
    output logic nack_irq,
    output logic start_irq,
    output logic stop_irq,
    // Clock line pin, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Data line pin
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Synchronous mode clock pin
    input wire logic clk_in,
    output logic clk_out,
    output logic clk_oe
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Tap k holds the level k+1 cycles back: extra delay 2..8
    function automatic logic twcsm_tap(input logic [2:0] sel,
                                       input logic [7:0] pipe,
                                       input logic now);
        twcsm_tap = (sel == 3'h0) ? now : pipe[sel];
    endfunction

    function automatic logic twcsm_mode(input logic two,
                                        input logic [2:0] fld,
                                        input logic want_two,
                                        input logic [2:0] want);
        twcsm_mode = (two == want_two) && (fld == want);
    endfunction

    twcsm_pkg::twcsm_state_t s_q;
    twcsm_pkg::twcsm_state_t s_d;

    logic [2:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic clk_s;
    logic twi;
    logic syn;
    logic pol;
    logic ph;
    logic ext;
    logic running;
    logic tn;
    logic rise;
    logic fall;
    logic smp;
    logic oute;
    logic start_c;
    logic stop_c;
    logic ackb;
    logic data_in;
    logic lvl_q;
    logic idle_ok;
    logic [3:0] width;

    logic fin;
    logic store;
    logic [8:0] store_val;
    logic [3:0] nb;
    logic lvl;
    logic dl;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    twcsm_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in({clk_in, sda_in, scl_in}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign clk_s = pins_s[2];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign twi = twcsm_mode(two_wire_mode_select, serial_mode_field,
                            1'b1, twcsm_pkg::MODE_TWI);
    assign syn = twcsm_mode(two_wire_mode_select, serial_mode_field,
                            1'b0, twcsm_pkg::MODE_SYNC);
    assign pol = syn && clock_polarity_bit;
    assign ph = syn && clock_phase_bit;
    assign ext = clock_source_select;
    assign running = (s_q.phase != twcsm_pkg::PH_IDLE);
    assign width = twi ? twcsm_pkg::TWI_BITS : twcsm_pkg::SYNC_BITS;

    // Clock normalised to idle high; twi with internal source uses the wired AND
    assign tn = ext ? (twi ? scl_s : (clk_s ^ pol))
                    : (twi ? (s_q.iclk & scl_s) : s_q.iclk);
    assign rise = tn && !s_q.tclk_prev;
    assign fall = !tn && s_q.tclk_prev;
    assign smp = ph ? fall : rise;
    assign oute = ph ? rise : fall;
    assign start_c = twi && scl_s && s_q.scl_prev
                     && s_q.sda_prev && !sda_s;
    assign stop_c = twi && scl_s && s_q.scl_prev
                    && !s_q.sda_prev && sda_s;
    assign ackb = (!condition_output_select && ack_drive_enable)
                  ? ack_value_bit : 1'b1;
    // Synchronous receive data shares the clock line pin
    assign data_in = twi ? sda_s : scl_s;
    assign lvl_q = running ? s_q.sda_bit : s_q.idle_lvl;
    assign idle_ok = !ext || tn;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        fin = 1'b0;
        store = 1'b0;
        store_val = 9'h000;
        nb = s_q.bit_cnt + 4'h1;
        lvl = 1'b1;
        dl = 1'b1;
        s_d.tx_irq = 1'b0;
        s_d.rx_irq = 1'b0;
        s_d.ack_irq = 1'b0;
        s_d.nack_irq = 1'b0;
        s_d.start_irq = 1'b0;
        s_d.stop_irq = 1'b0;
        s_d.tclk_prev = tn;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;

        if (rx_read) begin
            s_d.rx_full = 1'b0;
        end
        if (overrun_clear) begin
            s_d.overrun = 1'b0;
        end
        if (clock_wait_hold_wr) begin
            s_d.wait_hold = clock_wait_hold_wdata;
        end
        if (idle_level_wr && twcsm_mode(two_wire_mode_select,
                serial_mode_field, 1'b1, twcsm_pkg::MODE_OFF)) begin
            s_d.idle_lvl = idle_level_wdata;
        end
        if (!hold_after_ninth) begin
            s_d.hold9 = 1'b0;
        end

        // --------------------------------------------------------
        // Internal clock divider, half period n+1 cycles
        // --------------------------------------------------------
        if (running && !ext) begin
            if (twi && clock_sync_enable && s_q.iclk
                    && s_q.scl_prev && !scl_s) begin
                s_d.iclk = 1'b0;
                s_d.div_cnt = baud_divider;
            end else if (!(twi && clock_sync_enable
                    && s_q.iclk && !scl_s)) begin
                if (s_q.div_cnt == 8'h00) begin
                    s_d.iclk = !s_q.iclk;
                    s_d.div_cnt = baud_divider;
                end else begin
                    s_d.div_cnt = s_q.div_cnt - 8'h01;
                end
            end
        end

        // --------------------------------------------------------
        // Transfer sequencer
        // --------------------------------------------------------
        unique case (s_q.phase)
            twcsm_pkg::PH_IDLE: begin
                if ((twi || syn) && transmit_enable_bit && !s_q.empty
                        && idle_ok) begin
                    s_d.phase = twcsm_pkg::PH_RUN;
                    s_d.bit_cnt = 4'h0;
                    s_d.tx_sh = {s_q.tx_buf, ackb};
                    s_d.rx_sh = 8'h00;
                    s_d.ovr_now = 1'b0;
                    s_d.empty = 1'b1;
                    s_d.tx_irq = !transmit_irq_cause_select;
                    s_d.iclk = 1'b1;
                    s_d.div_cnt = baud_divider;
                    s_d.sda_bit = lvl_q;
                    if (ph) begin
                        // Delayed phase presents the first bit early
                        s_d.sda_bit = s_q.tx_buf[7];
                        s_d.tx_sh = {s_q.tx_buf[6:0], ackb, 1'b0};
                    end
                end
            end
            twcsm_pkg::PH_RUN: begin
                if (smp && s_q.bit_cnt < width) begin
                    s_d.bit_cnt = nb;
                    if (nb <= twcsm_pkg::DATA_BITS) begin
                        s_d.rx_sh = {s_q.rx_sh[6:0], data_in};
                    end
                    if (nb == twcsm_pkg::OVR_BIT && s_d.rx_full
                            && receive_enable_bit) begin
                        s_d.overrun = 1'b1;
                        s_d.ovr_now = 1'b1;
                    end
                    if (twi && nb == twcsm_pkg::TWI_BITS) begin
                        if (!ack_interrupt_mode) begin
                            s_d.nack_irq = data_in;
                            s_d.ack_irq = !data_in;
                            store = 1'b1;
                            store_val = {data_in, s_q.rx_sh};
                        end else if (clock_phase_bit
                                && receive_enable_bit) begin
                            s_d.rx_buf = {data_in, s_q.rx_sh};
                        end
                    end
                    if (syn && !ph && nb == twcsm_pkg::SYNC_BITS) begin
                        fin = 1'b1;
                    end
                end
                if (oute) begin
                    if (s_q.bit_cnt == width) begin
                        if (twi) begin
                            s_d.low_hold = s_q.wait_hold;
                            s_d.sda_bit = 1'b1;
                        end
                        if (twi && clock_phase_bit) begin
                            s_d.phase = twcsm_pkg::PH_EXTRA;
                        end else begin
                            fin = 1'b1;
                        end
                    end else begin
                        s_d.sda_bit = s_q.tx_sh[8];
                        s_d.tx_sh = {s_q.tx_sh[7:0], 1'b0};
                        if (twi && ack_interrupt_mode
                                && s_q.bit_cnt == twcsm_pkg::DATA_BITS)
                                begin
                            store = 1'b1;
                            store_val = {s_q.rx_sh[0], 1'b0,
                                         s_q.rx_sh[7:1]};
                        end
                    end
                end
            end
            twcsm_pkg::PH_EXTRA: begin
                if (oute) begin
                    s_d.hold9 = hold_after_ninth;
                    fin = 1'b1;
                end
            end
            default: begin
                s_d.phase = twcsm_pkg::PH_IDLE;
            end
        endcase

        if (fin) begin
            s_d.phase = twcsm_pkg::PH_IDLE;
            s_d.iclk = 1'b1;
            s_d.tx_irq = transmit_irq_cause_select;
            if (syn) begin
                store = 1'b1;
                store_val = {1'b0, s_d.rx_sh};
            end
        end

        // Overrun suppresses the receive event
        if (store && receive_enable_bit) begin
            s_d.rx_buf = store_val;
            s_d.rx_full = 1'b1;
            s_d.rx_irq = !s_d.ovr_now;
        end

        // --------------------------------------------------------
        // Bus conditions; set of wait hold wins over software
        // --------------------------------------------------------
        if (start_c) begin
            s_d.start_irq = 1'b1;
            if (init_on_start_enable) begin
                s_d.phase = twcsm_pkg::PH_RUN;
                s_d.bit_cnt = 4'h0;
                s_d.tx_sh = {s_q.tx_buf, ackb};
                s_d.sda_bit = lvl_q;
                s_d.rx_sh = 8'h00;
                s_d.ovr_now = 1'b0;
                s_d.wait_hold = 1'b1;
                s_d.iclk = 1'b1;
                s_d.div_cnt = baud_divider;
                s_d.low_hold = 1'b0;
                s_d.hold9 = 1'b0;
            end
        end
        if (stop_c) begin
            s_d.stop_irq = 1'b1;
            s_d.phase = twcsm_pkg::PH_IDLE;
            s_d.iclk = 1'b1;
            if (clock_release_on_stop) begin
                s_d.low_hold = 1'b0;
                s_d.hold9 = 1'b0;
            end
        end
        if (!s_d.wait_hold) begin
            s_d.low_hold = 1'b0;
        end

        // A write in the load cycle still counts as fresh data
        if (tx_write) begin
            s_d.tx_buf = tx_wdata;
            s_d.empty = 1'b0;
        end

        // --------------------------------------------------------
        // Pin drivers
        // --------------------------------------------------------
        lvl = (s_d.phase != twcsm_pkg::PH_IDLE) ? s_d.sda_bit
                                                : s_d.idle_lvl;
        s_d.dly = {s_q.dly[6:0], lvl};
        dl = twcsm_tap(data_delay_field, s_q.dly, lvl);
        s_d.sda_out = 1'b0;
        if (data_output_disable) begin
            s_d.sda_oe = 1'b0;
        end else if (syn) begin
            s_d.sda_oe = 1'b1;
            s_d.sda_out = dl;
        end else begin
            s_d.sda_oe = two_wire_mode_select && !dl;
        end
        s_d.scl_oe = twi && (clock_force_low
                     || s_d.low_hold
                     || s_d.hold9
                     || (s_d.phase != twcsm_pkg::PH_IDLE
                         && !ext && !s_d.iclk));
        s_d.clk_out = s_d.iclk ^ pol;
        s_d.clk_oe = syn && !ext;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= twcsm_pkg::STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain clock line never drives high
    assign scl_out = 1'b0;
    assign scl_oe = s_q.scl_oe;
    assign sda_out = s_q.sda_out;
    assign sda_oe = s_q.sda_oe;
    assign clk_out = s_q.clk_out;
    assign clk_oe = s_q.clk_oe;
    assign buffer_empty_flag = s_q.empty;
    assign receive_buffer = s_q.rx_buf;
    assign receive_full = s_q.rx_full;
    assign overrun_flag = s_q.overrun;
    assign clock_wait_hold = s_q.wait_hold;
    assign tx_irq = s_q.tx_irq;
    assign rx_irq = s_q.rx_irq;
    assign ack_irq = s_q.ack_irq;
    assign nack_irq = s_q.nack_irq;
    assign start_irq = s_q.start_irq;
    assign stop_irq = s_q.stop_irq;

endmodule

// [test/twcsm_core_props.sv]
`timescale 1ns/1ps
module twcsm_core_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Controls and pins
    input wire logic [2:0] serial_mode_field,
    input wire logic [2:0] data_delay_field,
    input wire logic clock_force_low,
    input wire logic data_output_disable,
    input wire logic init_on_start_enable,
    input wire logic transmit_irq_cause_select,
    input wire logic tx_write,
    input wire logic overrun_clear,
    input wire logic scl_in,
    input wire logic sda_in,
    // Outputs
    input wire logic buffer_empty_flag,
    input wire logic receive_full,
    input wire logic overrun_flag,
    input wire logic clock_wait_hold,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic ack_irq,
    input wire logic nack_irq,
    input wire logic start_irq,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire tw = serial_mode_field == twcsm_pkg::MODE_TWI;
    // Data falls while clock stays high long enough to pass the synchroniser
    sequence start_cond;
        (tw && scl_in && $fell(sda_in)) ##1 (scl_in && !sda_in)[*3];
    endsequence
    a_force_low: assert property ((tw && clock_force_low)[*2] |=> scl_oe)
        else $error("clock line not forced low");
    a_sda_disable: assert property
        ((data_output_disable && data_delay_field == 3'h0)[*3] |=> !sda_oe)
        else $error("data line still driven");
    a_write_fills: assert property (tx_write |=> !buffer_empty_flag)
        else $error("empty flag after write");
    a_ack_excl: assert property (!(ack_irq && nack_irq))
        else $error("ack and nack together");
    a_rx_full: assert property (rx_irq |-> ##[0:1] receive_full)
        else $error("receive event without data");
    a_overrun_hold: assert property
        (overrun_flag && !overrun_clear |=> overrun_flag)
        else $error("overrun flag lost");
    a_load_irq: assert property ($rose(buffer_empty_flag)
        && !transmit_irq_cause_select
        && serial_mode_field != twcsm_pkg::MODE_OFF |-> tx_irq)
        else $error("no transmit event at load");
    a_start_seen: assert property (start_cond |-> ##[0:3] start_irq)
        else $error("start condition missed");
    a_start_hold: assert property
        (start_irq && init_on_start_enable |-> ##[0:1] clock_wait_hold)
        else $error("wait hold not set on start");
endmodule
bind twcsm_core twcsm_core_props twcsm_core_props_inst (.*);

// [test/twcsm_peer.sv]
`timescale 1ns/1ps
module twcsm_peer (
    // Link
    input wire logic clk_pin,
    input wire logic pol,
    input wire logic mosi,
    output logic miso,
    // Test side
    input wire logic load,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    int cnt;
    wire sclk = clk_pin ^ pol;
    initial miso = 1'b1;
    always @(posedge load) begin
        sh = tx_byte;
        cnt = 0;
        miso = sh[7];
    end
    always @(posedge sclk) begin
        rx_byte = {rx_byte[6:0], mosi};
        cnt++;
    end
    always @(negedge sclk) begin
        // Past the frame the line no longer holds data
        miso = (cnt < 8) ? sh[7] : ~miso;
        sh = sh << 1;
    end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
failures++; $display("unexpected %s expected %h seen %h", n, e, a); end end
`define WAIT(s) begin n = 0; while (s !== 1'b1 && n < 300) begin \
@(negedge ref_clk); n++; end end
module testbench;
    logic ref_clk = 1'b0, reset_n = 1'b0, clk_in = 1'b1;
    logic two_wire_mode_select = 1'b0, clock_source_select = 1'b0;
    logic [2:0] serial_mode_field = 3'h0, data_delay_field = 3'h0;
    logic [7:0] baud_divider = 8'h03, tx_wdata = 8'h00, peer_tx = 8'h00;
    logic clock_phase_bit = 1'b0, clock_polarity_bit = 1'b0;
    logic clock_sync_enable = 1'b0, clock_force_low = 1'b0;
    logic hold_after_ninth = 1'b0, clock_release_on_stop = 1'b0;
    logic clock_wait_hold_wr = 1'b0, clock_wait_hold_wdata = 1'b0;
    logic data_output_disable = 1'b0, idle_level_wr = 1'b0;
    logic idle_level_wdata = 1'b0, ack_drive_enable = 1'b0;
    logic ack_value_bit = 1'b0, condition_output_select = 1'b0;
    logic ack_interrupt_mode = 1'b0, init_on_start_enable = 1'b0;
    logic transmit_enable_bit = 1'b0, receive_enable_bit = 1'b0;
    logic transmit_irq_cause_select = 1'b0, tx_write = 1'b0;
    logic rx_read = 1'b0, overrun_clear = 1'b0, pload = 1'b0;
    logic line_scl = 1'b1, line_sda = 1'b1;
    logic buffer_empty_flag, receive_full, overrun_flag, clock_wait_hold;
    logic tx_irq, rx_irq, ack_irq, nack_irq, start_irq, stop_irq;
    logic scl_out, scl_oe, sda_out, sda_oe, clk_out, clk_oe, miso;
    logic [8:0] receive_buffer;
    logic [7:0] peer_rx;
    int failures = 0, check_count = 0, cyc = 0, txc = 0, rxc = 0, n, t0;
    typedef struct packed {
        logic [7:0] tx; logic [7:0] rx; logic cause; logic pol;
    } twcsm_row_t;
    twcsm_row_t rows [4] = '{'{8'ha5, 8'h3c, 1'b0, 1'b0},
        '{8'h01, 8'h80, 1'b1, 1'b0}, '{8'hff, 8'h00, 1'b0, 1'b1},
        '{8'h5a, 8'hc3, 1'b1, 1'b1}};
    // Pulled-up open-drain lines; in synchronous mode RxD is the peer
    wire scl_in = two_wire_mode_select ? line_scl & ~scl_oe : miso;
    wire sda_in = two_wire_mode_select ? line_sda & ~sda_oe : 1'b1;
    twcsm_core twcsm_core_inst (.*);
    twcsm_peer twcsm_peer_inst (.clk_pin(clk_out),
        .pol(clock_polarity_bit), .mosi(sda_out), .miso(miso),
        .load(pload), .tx_byte(peer_tx), .rx_byte(peer_rx));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        txc += tx_irq;
        rxc += rx_irq;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic xfer(logic [7:0] d, logic [7:0] p);
        peer_tx <= p;
        tick(1);
        pload <= 1'b1;
        tx_wdata <= d;
        tx_write <= 1'b1;
        tick(1);
        pload <= 1'b0;
        tx_write <= 1'b0;
    endtask
    initial begin
        tick(10);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        `CHK("empty", 1'b1, buffer_empty_flag)
        `CHK("rxbuf", 9'h000, receive_buffer)
        $display("test reset done");
        // ----------------------------------------
        // Synchronous master rows
        // ----------------------------------------
        tick(1);
        serial_mode_field <= twcsm_pkg::MODE_SYNC;
        transmit_enable_bit <= 1'b1;
        receive_enable_bit <= 1'b1;
        foreach (rows[i]) begin
            clock_polarity_bit <= rows[i].pol;
            transmit_irq_cause_select <= rows[i].cause;
            tick(3);
            t0 = txc;
            xfer(rows[i].tx, rows[i].rx);
            tick(3);
            `CHK("load event", !rows[i].cause, 1'(txc - t0))
            `WAIT(rx_irq)
            `CHK("rx data", {1'b0, rows[i].rx}, receive_buffer)
            `CHK("clk oe", 1'b1, clk_oe)
            `CHK("peer data", rows[i].tx, peer_rx)
            tick(12);
            `CHK("tx events", 1'b1, 1'(txc - t0))
            rx_read <= 1'b1;
            tick(1);
            rx_read <= 1'b0;
            $display("test row %0d done", i);
        end
        xfer(8'h11, 8'h22);
        `WAIT(rx_irq)
        tick(2);
        t0 = rxc;
        xfer(8'h33, 8'h44);
        `WAIT(overrun_flag)
        `CHK("overrun", 1'b1, overrun_flag)
        tick(40);
        `CHK("rx events", 0, rxc - t0)
        overrun_clear <= 1'b1;
        rx_read <= 1'b1;
        tick(1);
        overrun_clear <= 1'b0;
        rx_read <= 1'b0;
        $display("test overrun done");
        // ----------------------------------------
        // Two-wire line control
        // ----------------------------------------
        two_wire_mode_select <= 1'b1;
        clock_source_select <= 1'b1;
        init_on_start_enable <= 1'b1;
        serial_mode_field <= twcsm_pkg::MODE_TWI;
        tick(6);
        line_sda <= 1'b0;
        `WAIT(start_irq)
        `CHK("start", 1'b1, start_irq)
        tick(2);
        `CHK("wait hold", 1'b1, clock_wait_hold)
        clock_force_low <= 1'b1;
        tick(4);
        `CHK("scl forced", 1'b1, scl_oe)
        clock_force_low <= 1'b0;
        data_output_disable <= 1'b1;
        tick(4);
        `CHK("sda off", 1'b0, sda_oe)
        // Kept off: the first data bit would hold the line low
        tick(4);
        line_sda <= 1'b1;
        `WAIT(stop_irq)
        `CHK("stop", 1'b1, stop_irq)
        data_output_disable <= 1'b0;
        $display("test two-wire done");
        stop_test();
    end
endmodule
